/* spdo_consts.vh */
// register offsets, reset values and scaling constants of the source object bank
`ifndef SPDO_CONSTS_VH
`define SPDO_CONSTS_VH
`define SPDO_ADDR_W        8
`define SPDO_DATA_W        8
`define SPDO_OFS_O4_VL     8'h0A
`define SPDO_OFS_O4_VH     8'h0B
`define SPDO_OFS_O4_I      8'h0C
`define SPDO_OFS_O5_VL     8'h0D
`define SPDO_OFS_O5_VH     8'h0E
`define SPDO_OFS_O5_I      8'h0F
`define SPDO_OFS_O6_VL     8'h10
`define SPDO_OFS_O6_VH     8'h11
`define SPDO_OFS_O6_I      8'h12
`define SPDO_OFS_O7_VL     8'h13
`define SPDO_OFS_O7_VH     8'h14
`define SPDO_OFS_O7_I      8'h15
`define SPDO_RST_O4_VL     8'hC8
`define SPDO_RST_O4_VH     8'h00
`define SPDO_RST_O4_I      8'h96
`define SPDO_RST_O5_VL     8'h21
`define SPDO_RST_O5_VH     8'h6E
`define SPDO_RST_O5_I      8'h3C
`define SPDO_RST_O6_VL     8'h21
`define SPDO_RST_O6_VH     8'hA0
`define SPDO_RST_O6_I      8'h3C
`define SPDO_RST_O7_VL     8'h21
`define SPDO_RST_O7_VH     8'hD2
`define SPDO_RST_O7_I      8'h3C
`define SPDO_RST_KIND      4'hE
`define SPDO_VSTEP_MV      16'h0064
`define SPDO_ISTEP_FIX_MA  16'h0014
`define SPDO_ISTEP_PPS_MA  16'h0032
`define SPDO_ICAP_MA       16'h0BB8
`define SPDO_VFIX_MAX_MV   16'h59BA
`define SPDO_READ_ERR      8'h00
`endif

/* spdo_obj_eval.v */
// forms one advertised object from its three registers, kind bit and cable rating
`include "spdo_consts.vh"
module spdo_obj_eval (
   input  wire        clk,
   input  wire        rst,
   input  wire        kind_pps,
   input  wire [7:0]  voltage_low,
   input  wire [7:0]  voltage_high,
   input  wire [7:0]  current_limit,
   input  wire        cable_5a,
   output reg  [15:0] adv_max_mv,
   output reg  [15:0] adv_min_mv,
   output reg  [15:0] adv_current_ma,
   output reg         adv_pps
);
   // ***************************************************
   // scaling helpers
   // ***************************************************
   function [15:0] scale;
      input [7:0]  code;
      input [15:0] step;
      reg   [23:0] prod;
      begin
         prod  = code * step;
         scale = prod[15:0];
      end
   endfunction

   reg [15:0] next_max;
   reg [15:0] next_min;
   reg [15:0] raw_ma;
   reg [15:0] next_ma;

   always @* begin
      if (kind_pps) begin
         next_max = scale(voltage_high, `SPDO_VSTEP_MV);
         next_min = scale(voltage_low, `SPDO_VSTEP_MV);
         raw_ma   = scale(current_limit, `SPDO_ISTEP_PPS_MA);
      end else begin
         // high byte is unused for a fixed object
         next_max = scale(voltage_low, `SPDO_VSTEP_MV);
         next_min = next_max;
         raw_ma   = scale(current_limit, `SPDO_ISTEP_FIX_MA);
      end
      // without a 5A cable anything above 3A is advertised as 3A
      if (raw_ma > `SPDO_ICAP_MA && !cable_5a) begin
         next_ma = `SPDO_ICAP_MA;
      end else begin
         next_ma = raw_ma;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         adv_max_mv     <= 16'h0000;
         adv_min_mv     <= 16'h0000;
         adv_current_ma <= 16'h0000;
         adv_pps        <= 1'b0;
      end else begin
         adv_max_mv     <= next_max;
         adv_min_mv     <= next_min;
         adv_current_ma <= next_ma;
         adv_pps        <= kind_pps;
      end
   end
endmodule

/* spdo_regs.v */
// source objects four to seven: register bank and advertised object values
//
// Behaviour
// - fixed: low register is voltage, 100mV
// - programmable: high register is upper bound
// - programmable: low register is lower bound
// - current step 20mA fixed, 50mA programmable
// - above 3A only with 5A cable
// - object four low voltage resets 0xC8
// - object four current resets 0x96
// - object five high voltage resets 0x6E
// - objects five-seven low voltage reset 0x21
// - object five current resets 0x3C
// - object six high voltage resets 0xA0
// - object seven high voltage resets 0xD2
// - objects six, seven current reset 3A programmable
// - kind bit: clear fixed, set programmable
`include "spdo_consts.vh"
module spdo_regs (
   input  wire        clk,
   input  wire        rst,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   output reg         reg_rvalid,
   input  wire        obj4_kind_select,
   input  wire        obj5_kind_select,
   input  wire        obj6_kind_select,
   input  wire        obj7_kind_select,
   input  wire        cable_5a,
   output wire [63:0] adv_max_mv,
   output wire [63:0] adv_min_mv,
   output wire [63:0] adv_current_ma,
   output wire [3:0]  adv_pps
);
   // ***************************************************
   // storage
   // ***************************************************
   reg [7:0] bank [0:11];
   reg [3:0] kind_sync1;
   reg [3:0] kind_sync2;
   reg       cable_sync1;
   reg       cable_sync2;
   integer   i;

   function [7:0] reset_of;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: reset_of = `SPDO_RST_O4_VL;
            4'h1: reset_of = `SPDO_RST_O4_VH;
            4'h2: reset_of = `SPDO_RST_O4_I;
            4'h3: reset_of = `SPDO_RST_O5_VL;
            4'h4: reset_of = `SPDO_RST_O5_VH;
            4'h5: reset_of = `SPDO_RST_O5_I;
            4'h6: reset_of = `SPDO_RST_O6_VL;
            4'h7: reset_of = `SPDO_RST_O6_VH;
            4'h8: reset_of = `SPDO_RST_O6_I;
            4'h9: reset_of = `SPDO_RST_O7_VL;
            4'hA: reset_of = `SPDO_RST_O7_VH;
            4'hB: reset_of = `SPDO_RST_O7_I;
            default: reset_of = 8'h00;
         endcase
      end
   endfunction

   wire       in_range = (reg_addr >= `SPDO_OFS_O4_VL) && (reg_addr <= `SPDO_OFS_O7_I);
   wire [7:0] rel      = reg_addr - `SPDO_OFS_O4_VL;
   wire [3:0] idx      = rel[3:0];

   // ***************************************************
   // host port
   // ***************************************************
   // no check of the fixed 22.97V ceiling: software owns that limit
   always @(posedge clk) begin
      if (rst) begin
         for (i = 0; i < 12; i = i + 1) begin
            bank[i] <= reset_of(i[3:0]);
         end
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         if (reg_wr && in_range) begin
            bank[idx] <= reg_wdata;
         end
         reg_rvalid <= reg_rd;
         if (reg_rd && in_range) begin
            reg_rdata <= bank[idx];
         end else if (reg_rd) begin
            reg_rdata <= `SPDO_READ_ERR;
         end
      end
   end

   // kind bits and cable rating come from other register groups and the cable probe
   always @(posedge clk) begin
      if (rst) begin
         kind_sync1  <= `SPDO_RST_KIND;
         kind_sync2  <= `SPDO_RST_KIND;
         cable_sync1 <= 1'b0;
         cable_sync2 <= 1'b0;
      end else begin
         kind_sync1  <= {obj7_kind_select, obj6_kind_select,
                         obj5_kind_select, obj4_kind_select};
         kind_sync2  <= kind_sync1;
         cable_sync1 <= cable_5a;
         cable_sync2 <= cable_sync1;
      end
   end

   // ***************************************************
   // advertised objects
   // ***************************************************
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : obj
         spdo_obj_eval u_eval (
            .clk            (clk),
            .rst            (rst),
            .kind_pps       (kind_sync2[g]),
            .voltage_low    (bank[3*g]),
            .voltage_high   (bank[3*g+1]),
            .current_limit  (bank[3*g+2]),
            .cable_5a       (cable_sync2),
            .adv_max_mv     (adv_max_mv[16*g+15:16*g]),
            .adv_min_mv     (adv_min_mv[16*g+15:16*g]),
            .adv_current_ma (adv_current_ma[16*g+15:16*g]),
            .adv_pps        (adv_pps[g])
         );
      end
   endgenerate
endmodule

/* spdo_regs_sva.sv */
// concurrent checks on the source object register bank ports
module spdo_regs_sva (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        obj4_kind_select,
   input wire logic        cable_5a,
   input wire logic [63:0] adv_max_mv,
   input wire logic [63:0] adv_min_mv,
   input wire logic [63:0] adv_current_ma,
   input wire logic [3:0]  adv_pps
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire mapped = reg_addr >= 8'h0A && reg_addr <= 8'h15;
   // a register write shows on the advertised field two edges later
   property p_scale(a, f, k);
      reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a) ##1 k
         |-> f == $past(reg_wdata, 2) * 16'h0064;
   endproperty
   chk_rvalid_pulse: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   chk_write_readback: assert property ((reg_wr && mapped) ##1
      (reg_rd && $stable(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("read back differs");
   chk_fixed_mirror: assert property (!adv_pps[0] |->
      adv_min_mv[15:0] == adv_max_mv[15:0]) else $error("fixed object bounds differ");
   chk_fixed_scale: assert property (p_scale(8'h0A, adv_max_mv[15:0], !adv_pps[0]))
      else $error("fixed voltage scale");
   chk_pps_upper: assert property (p_scale(8'h0E, adv_max_mv[31:16], adv_pps[1]))
      else $error("upper bound scale");
   chk_pps_lower: assert property (p_scale(8'h0D, adv_min_mv[31:16], adv_pps[1]))
      else $error("lower bound scale");
   chk_cap_three_amp: assert property (!cable_5a [*4] |->
      adv_current_ma[15:0] <= 16'h0BB8) else $error("current not capped");
   chk_kind_sync: assert property (obj4_kind_select [*4] |-> adv_pps[0])
      else $error("kind bit not followed");
   cover property (reg_rd ##1 reg_rvalid);
   cover property (cable_5a [*4] ##0 adv_current_ma[15:0] > 16'h0BB8);
   cover property (adv_pps == 4'hE ##1 adv_pps != 4'hE);
endmodule
bind spdo_regs spdo_regs_sva i_spdo_regs_sva (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .reg_rvalid, .obj4_kind_select, .cable_5a, .adv_max_mv,
   .adv_min_mv, .adv_current_ma, .adv_pps);

/* spdo_host_model.sv */
// host model: one byte request per edge, bus inverted when released
module spdo_host_model (
   input  wire logic       clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
   // caller is just past an edge; the answer is taken one edge later
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      logic low = a >= 8'h0A && a <= 8'h15 && (a - 8'h0A) % 3 == 0;
      {reg_wr, reg_rd, reg_addr} = {w, !w, a};
      reg_wdata = (low && d > 8'hE5) ? 8'hE5 : d;
      @(posedge clk);
      #1;
      q = reg_rvalid ? reg_rdata : 8'hXX;
   endtask
   task automatic idle;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~reg_addr, ~reg_wdata};
      @(posedge clk);
      #1;
   endtask
endmodule

/* tb_spdo_regs.sv */
// self-checking bench for the source object register bank
module tb_spdo_regs;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
   logic        clk = 1'b0, rst = 1'b1, cable_5a = 1'b0, reg_wr, reg_rd, reg_rvalid;
   logic [3:0]  kd = 4'hE, adv_pps;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, q, d;
   logic [63:0] adv_max_mv, adv_min_mv, adv_current_ma;
   logic [7:0]  sh [12];
   logic [7:0]  rv [12] = '{8'hC8, 8'h00, 8'h96, 8'h21, 8'h6E, 8'h3C, 8'h21, 8'hA0,
                            8'h3C, 8'h21, 8'hD2, 8'h3C};
   int          n_mismatch = 0, n_tests = 0, cyc = 0;
   spdo_regs i_spdo_regs (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .obj4_kind_select(kd[0]), .obj5_kind_select(kd[1]),
      .obj6_kind_select(kd[2]), .obj7_kind_select(kd[3]), .cable_5a, .adv_max_mv,
      .adv_min_mv, .adv_current_ma, .adv_pps);
   spdo_host_model i_spdo_host_model (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_rvalid);
   function automatic logic [47:0] expo(input logic k, c, input logic [7:0] vl, vh, ic);
      logic [15:0] mn, mx, cu;
      mn = vl * 16'h0064;
      mx = k ? vh * 16'h0064 : mn;
      cu = ic * (k ? 16'h0032 : 16'h0014);
      if (!c && cu > 16'h0BB8) cu = 16'h0BB8;
      return {mx, mn, cu};
   endfunction
   task automatic cmp_adv;
      logic [47:0] g, e;
      for (int o = 0; o < 4; o++) begin
         g = {adv_max_mv[o*16+:16], adv_min_mv[o*16+:16], adv_current_ma[o*16+:16]};
         e = expo(kd[o], cable_5a, sh[o*3], sh[o*3+1], sh[o*3+2]);
         `CHK(g, e)
      end
      `CHK(adv_pps, kd)
   endtask
   // reads every register back at its reset value, then takes those as the shadow
   task automatic chk_reset;
      for (int i = 0; i < 12; i++) begin
         i_spdo_host_model.xfer(1'b0, 8'h0A + 8'(i), 8'h00, q);
         `CHK(q, rv[i])
      end
      sh = rv;
   endtask
   task automatic test_done;
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done;
      end
   end
   initial begin
      void'($urandom(72826));
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      chk_reset;
      i_spdo_host_model.xfer(1'b1, 8'h09, 8'h5A, q);
      i_spdo_host_model.xfer(1'b0, 8'h09, 8'h00, q);
      `CHK(q, 8'h00)
      i_spdo_host_model.xfer(1'b1, 8'h0C, 8'hFA, q);
      sh[2] = 8'hFA;
      i_spdo_host_model.idle;
      cmp_adv;
      cable_5a = 1'b1;
      repeat (3) i_spdo_host_model.idle;
      cmp_adv;
      for (int j = 0; j < 24; j++) begin
         kd = (j < 12) ? 4'hE : 4'($urandom);
         cable_5a = 1'($urandom);
         d = 8'($urandom);
         if (j % 3 == 0) d = d % 8'hE6; // keep fixed voltages legal
         sh[j%12] = d;
         repeat (3) i_spdo_host_model.idle;
         i_spdo_host_model.xfer(1'b1, 8'h0A + 8'(j % 12), d, q);
         i_spdo_host_model.xfer(1'b0, 8'h0A + 8'(j % 12), 8'h00, q);
         `CHK(q, d)
         i_spdo_host_model.idle;
         cmp_adv;
      end
      // mid-run reset must wipe every written value
      rst = 1'b1;
      repeat (2) i_spdo_host_model.idle;
      rst = 1'b0;
      chk_reset;
      cmp_adv;
      test_done;
   end
endmodule
